/* design/i2c_master_receive_controller.sv */
// I2C multi-master controller with AXI4-Lite register access
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/10ps
module i2c_master_receive_controller (
  input  wire logic                         clk,
  input  wire logic                         nrst,
  input  wire logic [i2c_ctrl_pkg::AW-1:0] awaddr,
  input  wire logic                         awvalid,
  output logic                              awready,
  input  wire logic [31:0]                  wdata,
  input  wire logic [3:0]                   wstrb,
  input  wire logic                         wvalid,
  output logic                              wready,
  output logic [1:0]                        bresp,
  output logic                              bvalid,
  input  wire logic                         bready,
  input  wire logic [i2c_ctrl_pkg::AW-1:0] araddr,
  input  wire logic                         arvalid,
  output logic                              arready,
  output logic [31:0]                       rdata,
  output logic [1:0]                        rresp,
  output logic                              rvalid,
  input  wire logic                         rready,
  input  wire logic                         sclIn,
  output logic                              sclOut,
  output logic                              sclOe,
  input  wire logic                         sdaIn,
  output logic                              sdaOut,
  output logic                              sdaOe,
  output logic                              dmaTxReq,
  output logic                              dmaRxReq
);
  typedef enum logic [2:0] {S_IDLE, S_START, S_BIT, S_WAIT, S_XTRA, S_STOP} state_t;
  typedef enum logic [1:0] {P_LO, P_HI, P_END} phase_t;

  function automatic logic hit(input logic [i2c_ctrl_pkg::AW-1:0] a, input logic [31:0] idx);
    hit = a[i2c_ctrl_pkg::AW-1:2] == idx[i2c_ctrl_pkg::AW-3:0];
  endfunction : hit

  logic [7:0]  ctrl1_r;
  logic [7:0]  mode_r;
  logic [7:0]  opt_r;
  logic [7:0]  txd_r;
  logic [7:0]  rxd_r;
  logic        tdre_r;
  logic        receive_full_flag_r;
  logic [4:0]  stk_r;
  logic        ackRx_r;
  logic        startPend_r;
  logic        stopPend_r;
  state_t      state_r;
  state_t      state_nxt;
  phase_t      ph_r;
  phase_t      ph_nxt;
  logic [7:0]  cnt_r;
  logic [7:0]  cnt_nxt;
  logic [3:0]  bit_r;
  logic [3:0]  bit_nxt;
  logic [7:0]  sh_r;
  logic [7:0]  sh_nxt;
  logic        sclLow_r;
  logic        sclLow_nxt;
  logic        sdaLow_r;
  logic        sdaLow_nxt;
  logic        ackRx_nxt;
  logic [2:0]  sclS_r;
  logic [2:0]  sdaS_r;
  logic        sclF_r;
  logic        sdaF_r;
  logic        evLoad;
  logic        evRx;
  logic        evTend;
  logic        evNack;
  logic        evStop;
  logic        evAl;
  logic        evOvr;
  logic        startDone;
  logic        stopDone;
  logic [i2c_ctrl_pkg::AW-1:0] awAddr_r;
  logic        awHeld_r;
  logic [7:0]  wByte_r;
  logic        wLane_r;
  logic        wHeld_r;

  // Register fields
  wire         interface_enable    = ctrl1_r[i2c_ctrl_pkg::C1_ICE];
  wire         receive_disable   = ctrl1_r[i2c_ctrl_pkg::C1_RECEIVE_DISABLE];
  wire         mst    = ctrl1_r[i2c_ctrl_pkg::C1_MST];
  wire         transmit_select    = ctrl1_r[i2c_ctrl_pkg::C1_TRS];
  wire  [3:0]  clock_select    = ctrl1_r[i2c_ctrl_pkg::CKS_MSB:0];
  wire         bit_order_select    = mode_r[i2c_ctrl_pkg::MD_MLS];
  wire  [2:0]  bc     = mode_r[i2c_ctrl_pkg::BC_MSB:0];
  wire         ackLvl = opt_r[i2c_ctrl_pkg::OP_ACKL];
  wire         fs     = opt_r[i2c_ctrl_pkg::OP_FS];
  wire         busy   = state_r != S_IDLE;

  // Bit timing
  wire  [7:0]  div      = (clock_select == i2c_ctrl_pkg::CKS_0101) ? i2c_ctrl_pkg::DIV_0101 : i2c_ctrl_pkg::DIV_OTHER;
  wire  [7:0]  half     = {1'b0, div[7:1]};
  wire  [7:0]  quarter  = {2'b00, div[7:2]};
  wire         cntZero  = cnt_r == 8'h00;
  wire         hiWait   = (ph_r == P_HI) && cntZero && !sclF_r;
  wire         rise     = (ph_r == P_HI) && cntZero && sclF_r;
  wire         phEnd    = !hiWait && (cnt_r == half - 8'h01);
  wire         qHit     = (ph_r == P_LO) && (cnt_r == quarter);
  wire  [7:0]  cntAdv   = hiWait ? cnt_r : (phEnd ? 8'h00 : cnt_r + 8'h01);

  // Frame layout
  wire  [3:0]  dataBits = (bc == i2c_ctrl_pkg::BC_I2C9) ? i2c_ctrl_pkg::DATA_BITS : {1'b0, bc};
  wire         ackBit   = !fs && (bit_r == dataBits);
  wire         lastBit  = fs ? (bit_r == dataBits - 4'h1) : ackBit;
  wire         firstBit = bit_r == 4'h0;
  wire         outBit   = bit_order_select ? sh_r[0] : sh_r[7];
  wire  [7:0]  shIn     = bit_order_select ? {sdaF_r, sh_r[7:1]} : {sh_r[6:0], sdaF_r};

  // Register bus decode
  wire         arHs   = arvalid && arready;
  wire         doWr   = awHeld_r && wHeld_r && !bvalid;
  wire         wrOk   = doWr && wLane_r;
  wire         wrC1   = wrOk && hit(awAddr_r, i2c_ctrl_pkg::IDX_CTRL1);
  wire         wrC2   = wrOk && hit(awAddr_r, i2c_ctrl_pkg::IDX_CTRL2);
  wire         wrMd   = wrOk && hit(awAddr_r, i2c_ctrl_pkg::IDX_MODE);
  wire         wrOpt  = wrOk && hit(awAddr_r, i2c_ctrl_pkg::IDX_OPT);
  wire         wrSt   = wrOk && hit(awAddr_r, i2c_ctrl_pkg::IDX_STAT);
  wire         wrTx   = wrOk && hit(awAddr_r, i2c_ctrl_pkg::IDX_TXD);
  wire         wrStart = wrC2 && wByte_r[i2c_ctrl_pkg::C2_START];
  wire         wrStop  = wrC2 && wByte_r[i2c_ctrl_pkg::C2_STOP];
  wire         wrMap  = hit(awAddr_r, i2c_ctrl_pkg::IDX_CTRL1) || hit(awAddr_r, i2c_ctrl_pkg::IDX_CTRL2)
                     || hit(awAddr_r, i2c_ctrl_pkg::IDX_MODE) || hit(awAddr_r, i2c_ctrl_pkg::IDX_OPT)
                     || hit(awAddr_r, i2c_ctrl_pkg::IDX_STAT) || hit(awAddr_r, i2c_ctrl_pkg::IDX_TXD)
                     || hit(awAddr_r, i2c_ctrl_pkg::IDX_RXD);
  wire         rdC1   = hit(araddr, i2c_ctrl_pkg::IDX_CTRL1);
  wire         rdC2   = hit(araddr, i2c_ctrl_pkg::IDX_CTRL2);
  wire         rdMd   = hit(araddr, i2c_ctrl_pkg::IDX_MODE);
  wire         rdOpt  = hit(araddr, i2c_ctrl_pkg::IDX_OPT);
  wire         rdSt   = hit(araddr, i2c_ctrl_pkg::IDX_STAT);
  wire         rdTx   = hit(araddr, i2c_ctrl_pkg::IDX_TXD);
  wire         rdRx   = hit(araddr, i2c_ctrl_pkg::IDX_RXD);
  wire         rdMap  = rdC1 || rdC2 || rdMd || rdOpt || rdSt || rdTx || rdRx;
  wire         rxTake = arHs && rdRx;
  wire  [7:0]  c2Val  = {busy, startPend_r, stopPend_r, 1'b0, sclF_r, sdaF_r, 2'h0};
  wire  [7:0]  mdVal  = {bit_order_select, 4'h0, bc};
  wire  [7:0]  stVal  = {tdre_r, receive_full_flag_r, stk_r, ackRx_r};
  wire  [7:0]  rdByte = rdC1 ? ctrl1_r : rdC2 ? c2Val : rdMd ? mdVal : rdOpt ? opt_r
                      : rdSt ? stVal : rdTx ? txd_r : rdRx ? rxd_r : i2c_ctrl_pkg::RST_BYTE;
  wire  [4:0]  stkSet = {evTend, evNack, evStop, evAl, evOvr};
  wire  [4:0]  stkClr = wrSt ? wByte_r[i2c_ctrl_pkg::STK_HI:i2c_ctrl_pkg::STK_LO] : 5'h00;

  // Where the engine goes after a byte or while waiting
  wire state_t resumeSt = stopPend_r ? S_STOP : startPend_r ? S_START
                        : transmit_select ? (tdre_r ? S_WAIT : S_BIT) : (receive_disable ? S_WAIT : S_BIT);

  always_comb
  begin
    state_nxt  = state_r;
    ph_nxt     = ph_r;
    cnt_nxt    = cntAdv;
    bit_nxt    = bit_r;
    sh_nxt     = sh_r;
    sclLow_nxt = sclLow_r;
    sdaLow_nxt = sdaLow_r;
    ackRx_nxt  = ackRx_r;
    evLoad     = 1'b0;
    evRx       = 1'b0;
    evTend     = 1'b0;
    evNack     = 1'b0;
    evStop     = 1'b0;
    evAl       = 1'b0;
    evOvr      = 1'b0;
    startDone  = 1'b0;
    stopDone   = 1'b0;
    if (!interface_enable)
    begin
      state_nxt  = S_IDLE;
      sclLow_nxt = 1'b0;
      sdaLow_nxt = 1'b0;
      cnt_nxt    = 8'h00;
      startDone  = 1'b1;
      stopDone   = 1'b1;
    end
    else
    begin
      unique case (state_r)
        S_IDLE:
        begin
          cnt_nxt    = 8'h00;
          sclLow_nxt = 1'b0;
          sdaLow_nxt = 1'b0;
          stopDone   = stopPend_r;
          bit_nxt    = 4'h0;
          if (startPend_r && mst && fs)
          begin
            startDone = 1'b1;
            ph_nxt    = P_LO;
            state_nxt = S_BIT;
            sclLow_nxt = 1'b1;
          end
          else if (startPend_r && mst && sclF_r && sdaF_r)
          begin
            ph_nxt    = P_HI;
            state_nxt = S_START;
          end
        end
        S_START:
        begin
          if (fs)
          begin
            startDone = 1'b1;
            state_nxt = S_BIT;
          end
          else if (qHit)
            sdaLow_nxt = 1'b0;
          if (!fs && phEnd)
          begin
            unique case (ph_r)
              P_LO:
              begin
                ph_nxt     = P_HI;
                sclLow_nxt = 1'b0;
              end
              P_HI:
              begin
                ph_nxt     = P_END;
                sdaLow_nxt = 1'b1;
              end
              P_END:
              begin
                ph_nxt     = P_LO;
                sclLow_nxt = 1'b1;
                startDone  = 1'b1;
                bit_nxt    = 4'h0;
                state_nxt  = S_BIT;
              end
            endcase
          end
        end
        S_BIT:
        begin
          if (ph_r == P_LO)
          begin
            if (cntZero && firstBit && transmit_select && tdre_r)
              cnt_nxt = cnt_r;
            else if (cntZero && firstBit && transmit_select)
            begin
              sh_nxt = txd_r;
              evLoad = 1'b1;
            end
            if (cntZero && ackBit && !transmit_select && receive_full_flag_r)
              cnt_nxt = cnt_r;
            else if (cntZero && ackBit && !transmit_select)
              evRx = 1'b1;
            if (qHit)
              sdaLow_nxt = ackBit ? (!transmit_select && !ackLvl) : (transmit_select && !outBit);
            if (phEnd)
            begin
              ph_nxt     = P_HI;
              sclLow_nxt = 1'b0;
            end
          end
          else
          begin
            if (rise && ackBit)
            begin
              ackRx_nxt = sdaF_r;
              evNack    = transmit_select && sdaF_r;
            end
            else if (rise)
              sh_nxt = shIn;
            if (rise && !ackBit && transmit_select && !fs && !sdaLow_r && !sdaF_r)
            begin
              evAl       = 1'b1;
              state_nxt  = S_IDLE;
              sclLow_nxt = 1'b0;
              sdaLow_nxt = 1'b0;
              stopDone   = 1'b1;
            end
            else if (phEnd)
            begin
              sclLow_nxt = 1'b1;
              ph_nxt     = P_LO;
              bit_nxt    = bit_r + 4'h1;
              if (lastBit)
              begin
                bit_nxt   = 4'h0;
                evTend    = transmit_select && tdre_r;
                evRx      = fs && !transmit_select && !receive_full_flag_r;
                evOvr     = fs && !transmit_select && receive_full_flag_r;
                state_nxt = ((wrStart || wrStop) && !fs) ? S_XTRA : resumeSt;
              end
            end
          end
        end
        S_WAIT:
        begin
          sclLow_nxt = 1'b1;
          cnt_nxt    = 8'h00;
          ph_nxt     = P_LO;
          state_nxt  = resumeSt;
        end
        S_XTRA:
        begin
          if (qHit)
            sdaLow_nxt = 1'b0;
          if (phEnd && ph_r == P_LO)
          begin
            ph_nxt     = P_HI;
            sclLow_nxt = 1'b0;
          end
          else if (phEnd)
          begin
            ph_nxt     = P_LO;
            sclLow_nxt = 1'b1;
            state_nxt  = resumeSt;
          end
        end
        S_STOP:
        begin
          if (fs)
          begin
            stopDone  = 1'b1;
            state_nxt = S_IDLE;
          end
          else if (qHit)
            sdaLow_nxt = 1'b1;
          if (!fs && phEnd)
          begin
            unique case (ph_r)
              P_LO:
              begin
                ph_nxt     = P_HI;
                sclLow_nxt = 1'b0;
              end
              P_HI:
              begin
                ph_nxt     = P_END;
                sdaLow_nxt = 1'b0;
              end
              P_END:
              begin
                stopDone  = 1'b1;
                evStop    = 1'b1;
                state_nxt = S_IDLE;
              end
            endcase
          end
        end
      endcase
    end
  end

  // Pin synchronisers: a change counts once stages two and three agree
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sclS_r <= 3'h7;
      sdaS_r <= 3'h7;
      sclF_r <= 1'b1;
      sdaF_r <= 1'b1;
    end
    else
    begin
      sclS_r <= {sclS_r[1:0], sclIn};
      sdaS_r <= {sdaS_r[1:0], sdaIn};
      sclF_r <= (sclS_r[1] == sclS_r[2]) ? sclS_r[1] : sclF_r;
      sdaF_r <= (sdaS_r[1] == sdaS_r[2]) ? sdaS_r[1] : sdaF_r;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r  <= S_IDLE;
      ph_r     <= P_LO;
      cnt_r    <= 8'h00;
      bit_r    <= 4'h0;
      sh_r     <= 8'h00;
      sclLow_r <= 1'b0;
      sdaLow_r <= 1'b0;
      ackRx_r  <= 1'b0;
    end
    else
    begin
      state_r  <= state_nxt;
      ph_r     <= ph_nxt;
      cnt_r    <= cnt_nxt;
      bit_r    <= bit_nxt;
      sh_r     <= sh_nxt;
      sclLow_r <= sclLow_nxt;
      sdaLow_r <= sdaLow_nxt;
      ackRx_r  <= ackRx_nxt;
    end
  end

  // Software registers and flags; a hardware set wins over a clear
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl1_r     <= i2c_ctrl_pkg::RST_BYTE;
      mode_r      <= i2c_ctrl_pkg::RST_BYTE;
      opt_r       <= i2c_ctrl_pkg::RST_BYTE;
      txd_r       <= i2c_ctrl_pkg::RST_BYTE;
      rxd_r       <= i2c_ctrl_pkg::RST_BYTE;
      tdre_r      <= 1'b1;
      receive_full_flag_r      <= 1'b0;
      stk_r       <= 5'h00;
      startPend_r <= 1'b0;
      stopPend_r  <= 1'b0;
      dmaTxReq    <= 1'b0;
      dmaRxReq    <= 1'b0;
    end
    else
    begin
      if (wrC1)
        ctrl1_r <= wByte_r;
      if (wrMd)
        mode_r <= {wByte_r[i2c_ctrl_pkg::MD_MLS], 4'h0,
                   wByte_r[i2c_ctrl_pkg::MD_BIT_COUNT_WRITE_PROTECT] ? bc : wByte_r[i2c_ctrl_pkg::BC_MSB:0]};
      if (wrOpt)
        opt_r <= wByte_r;
      if (wrTx)
        txd_r <= wByte_r;
      if (evRx)
        rxd_r <= sh_r;
      tdre_r      <= evLoad || (tdre_r && !wrTx);
      receive_full_flag_r      <= evRx || (receive_full_flag_r && !rxTake);
      stk_r       <= stkSet | (stk_r & ~stkClr);
      startPend_r <= wrStart || (startPend_r && !startDone);
      stopPend_r  <= wrStop || (stopPend_r && !stopDone);
      dmaTxReq    <= opt_r[i2c_ctrl_pkg::OP_TXDMA] && interface_enable && transmit_select && tdre_r;
      dmaRxReq    <= opt_r[i2c_ctrl_pkg::OP_RXDMA] && interface_enable && receive_full_flag_r;
    end
  end

  // AXI4-Lite slave: address and data taken in either order, one access of each kind
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      awready  <= 1'b1;
      wready   <= 1'b1;
      awHeld_r <= 1'b0;
      wHeld_r  <= 1'b0;
      awAddr_r <= '0;
      wByte_r  <= 8'h00;
      wLane_r  <= 1'b0;
      bvalid   <= 1'b0;
      bresp    <= i2c_ctrl_pkg::RESP_OKAY;
      arready  <= 1'b1;
      rvalid   <= 1'b0;
      rdata    <= 32'h0000_0000;
      rresp    <= i2c_ctrl_pkg::RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awready  <= 1'b0;
        awHeld_r <= 1'b1;
        awAddr_r <= awaddr;
      end
      if (wvalid && wready)
      begin
        wready  <= 1'b0;
        wHeld_r <= 1'b1;
        wByte_r <= wdata[7:0];
        wLane_r <= wstrb[0];
      end
      if (doWr)
      begin
        awHeld_r <= 1'b0;
        wHeld_r  <= 1'b0;
        bvalid   <= 1'b1;
        bresp    <= wrMap ? i2c_ctrl_pkg::RESP_OKAY : i2c_ctrl_pkg::RESP_SLVERR;
      end
      if (bvalid && bready)
      begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
      if (arHs)
      begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= {24'h000000, rdByte};
        rresp   <= rdMap ? i2c_ctrl_pkg::RESP_OKAY : i2c_ctrl_pkg::RESP_SLVERR;
      end
      if (rvalid && rready)
      begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // Open-drain pins: the enable pulls the line low
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOe  = sclLow_r;
  assign sdaOe  = sdaLow_r;
endmodule : i2c_master_receive_controller

/* design/i2c_ctrl_pkg.sv */
// Register map, field positions and bit timing of the I2C master receive controller
package i2c_ctrl_pkg;
  localparam int AW = 12;
  // Register indices; the byte address is four times the index, low AW bits decoded
  localparam logic [31:0] IDX_CTRL1 = 32'hfffee400;
  localparam logic [31:0] IDX_CTRL2 = 32'hfffee401;
  localparam logic [31:0] IDX_MODE  = 32'hfffee402;
  localparam logic [31:0] IDX_OPT   = 32'hfffee403;
  localparam logic [31:0] IDX_STAT  = 32'hfffee404;
  localparam logic [31:0] IDX_TXD   = 32'hfffee405;
  localparam logic [31:0] IDX_RXD   = 32'hfffee406;
  // bus_control_one fields
  localparam int C1_ICE   = 7;
  localparam int C1_RECEIVE_DISABLE  = 6;
  localparam int C1_MST   = 5;
  localparam int C1_TRS   = 4;
  localparam int CKS_MSB  = 3;
  // bus_control_two request bits
  localparam int C2_START = 6;
  localparam int C2_STOP  = 5;
  // bus_mode fields
  localparam int MD_MLS   = 7;
  localparam int MD_BIT_COUNT_WRITE_PROTECT  = 3;
  localparam int BC_MSB   = 2;
  // bus_option fields
  localparam int OP_ACKL  = 7;
  localparam int OP_FS    = 6;
  localparam int OP_TXDMA = 1;
  localparam int OP_RXDMA = 0;
  // Sticky status flags occupy these bits of status_register
  localparam int STK_HI   = 5;
  localparam int STK_LO   = 1;
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [3:0] CKS_0101  = 4'h5;
  localparam logic [7:0] DIV_0101  = 8'h5c;
  localparam logic [7:0] DIV_OTHER = 8'hc8;
  localparam logic [2:0] BC_I2C9   = 3'h0;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : i2c_ctrl_pkg

/* verif/i2c_ctrl_monitor.sv */
// Port-level assertions for the I2C master receive controller
`timescale 1ns/10ps
module i2c_ctrl_monitor (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        awready,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        sclOut,
  input wire logic        sclOe,
  input wire logic        sdaOut,
  input wire logic        dmaRxReq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  b_release_a: assert property (bvalid && bready |=> !bvalid && awready && wready)
    else $error("write channel not reopened");
  r_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer late");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  rdata_zero_a: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  pins_drain_a: assert property (sclOut == 1'b0 && sdaOut == 1'b0)
    else $error("pin driven high");
  scl_high_a: assert property ($fell(sclOe) |-> !sclOe [*8])
    else $error("SCL high phase short");
  scl_low_a: assert property ($rose(sclOe) |-> sclOe [*8])
    else $error("SCL low phase short");
  dma_rx_a: assert property ($rose(dmaRxReq) |-> sclOe)
    else $error("receive request outside SCL low");
  cover property (bvalid && bready && bresp == i2c_ctrl_pkg::RESP_SLVERR);
  cover property ($rose(dmaRxReq));
  cover property ($fell(sclOe));
endmodule : i2c_ctrl_monitor
bind i2c_master_receive_controller i2c_ctrl_monitor i_mon (.*);

/* verif/i2c_eeprom_model.sv */
// Behavioural serial memory answering sequential reads
`timescale 1ns/10ps
module i2c_eeprom_model #(
  parameter logic [7:0] BASE = 8'h40
) (
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            sdaOe,
  output logic [7:0]      ackLog
);
  int         cnt = 0;
  logic       act = 1'b0;
  logic [7:0] addr = BASE;
  logic [7:0] q;
  initial sdaOe = 1'b0;
  initial ackLog = 8'h00;
  // Start opens a read, stop drops it
  always @(negedge sda) if (scl) {act, cnt} = {1'b1, -32'sd1};
  always @(posedge sda) if (scl) {act, sdaOe} = 2'b00;
  always @(negedge scl) if (act)
  begin
    cnt = cnt + 1;
    if (cnt == 9) {cnt, addr} = {32'd0, addr + 8'h01};
    q = addr * 8'h3b + 8'h11;
    sdaOe = (cnt < 8) ? ~q[7 - cnt] : 1'b0;
  end
  // Not-acknowledge ends the read; next read goes on at the following address
  always @(posedge scl) if (act && cnt == 8)
  begin
    ackLog = {ackLog[6:0], sda};
    if (sda) {act, addr} = {1'b0, addr + 8'h01};
  end
endmodule : i2c_eeprom_model

/* verif/i2c_master_receive_controller_tb.sv */
// Self-checking bench: register access and sequential reads from a serial memory
`timescale 1ns/10ps
module i2c_master_receive_controller_tb;
  logic        clk = 1'b0, nrst = 1'b0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'hf;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, sclOut, sclOe, sdaOut, sdaOe, memOe, dmaTxReq, dmaRxReq;
  logic [1:0]  bresp, rresp, rr;
  logic [7:0]  rv, ackLog, tx;
  logic [7:0]  expQ[$];
  int          bad_count = 0, comparisons = 0, n, m, k;
  wire         sclW = !sclOe;
  wire         sdaW = !(sdaOe || memOe);
  always #4 clk = ~clk;
  i2c_master_receive_controller i_dut (.sclIn(sclW), .sdaIn(sdaW), .*);
  i2c_eeprom_model i_mem (.scl(sclW), .sda(sdaW), .sdaOe(memOe), .ackLog(ackLog));
  function automatic logic [11:0] a(input logic [31:0] idx);
    return 12'(idx << 2);
  endfunction : a
  task automatic test_done;
    if (bad_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] v);
    comparisons++;
    if (v !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", s, e, v);
    end
  endtask : chk
  task automatic tmo;
    chk("timeout", 8'h00, 8'h01);
    test_done();
  endtask : tmo
  task automatic wr(input logic [11:0] ad, input logic [7:0] d, input logic [1:0] r = 2'h0);
    int i;
    @(posedge clk);
    awaddr <= ad;
    wdata <= {24'h0, d};
    {awvalid, wvalid, bready} <= 3'b111;
    for (i = 0; i < 40; i++)
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    bready <= 1'b0;
    if (i == 40) tmo();
    chk("bresp", {6'h0, r}, {6'h0, bresp});
  endtask : wr
  task automatic rx(input logic [11:0] ad);
    int i;
    @(posedge clk);
    araddr <= ad;
    {arvalid, rready} <= 2'b11;
    for (i = 0; i < 40; i++)
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    rready <= 1'b0;
    if (i == 40) tmo();
    {rv, rr} = {rdata[7:0], rresp};
  endtask : rx
  task automatic rd(input logic [11:0] ad, input logic [7:0] mk, input logic [7:0] e, input logic [1:0] r = 2'h0);
    rx(ad);
    chk("rdata", e & mk, rv & mk);
    chk("rresp", {6'h0, r}, {6'h0, rr});
  endtask : rd
  task automatic waitb(input logic [11:0] ad, input int b, input logic v);
    int i;
    for (i = 0; i < 400; i++)
    begin
      rx(ad);
      if (rv[b] === v) return;
    end
    tmo();
  endtask : waitb
  task automatic sclTo(input logic v, output int c);
    for (c = 0; c < 600 && sclW !== v; c++) @(posedge clk);
    if (c == 600) tmo();
  endtask : sclTo
  initial
  begin
    tx = 8'($urandom(32'hbbbf));
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rd(a(i2c_ctrl_pkg::IDX_CTRL1), 8'hff, 8'h00);
    rd(a(i2c_ctrl_pkg::IDX_STAT), 8'hff, 8'h80);
    rd(12'h01c, 8'hff, 8'h00, i2c_ctrl_pkg::RESP_SLVERR);
    wr(12'h01c, 8'hff, i2c_ctrl_pkg::RESP_SLVERR);
    wr(a(i2c_ctrl_pkg::IDX_CTRL1), 8'ha5);
    wr(a(i2c_ctrl_pkg::IDX_MODE), 8'h00);
    wr(a(i2c_ctrl_pkg::IDX_OPT), 8'h01);
    rd(a(i2c_ctrl_pkg::IDX_CTRL1), 8'hff, 8'ha5);
    for (k = 0; k < 4; k++) expQ.push_back(8'(8'h40 + k) * 8'h3b + 8'h11);
    wr(a(i2c_ctrl_pkg::IDX_CTRL2), 8'h40);
    sclTo(1'b0, n);
    sclTo(1'b1, n);
    sclTo(1'b0, m);
    chk("sclPeriod", 8'h01, {7'h0, n + m >= 90 && n + m <= 100});
    for (k = 0; k < 3; k++)
    begin
      waitb(a(i2c_ctrl_pkg::IDX_STAT), 6, 1'b1);
      chk("dmaRxReq", 8'h01, {7'h0, dmaRxReq});
      if (k == 1)
      begin
        sclTo(1'b1, n);
        sclTo(1'b0, n);
        wr(a(i2c_ctrl_pkg::IDX_OPT), 8'h81);
      end
      if (k == 2)
      begin
        waitb(a(i2c_ctrl_pkg::IDX_CTRL2), 3, 1'b0);
        wr(a(i2c_ctrl_pkg::IDX_CTRL2), 8'h20);
      end
      rd(a(i2c_ctrl_pkg::IDX_RXD), 8'hff, expQ.pop_front());
    end
    waitb(a(i2c_ctrl_pkg::IDX_CTRL2), 7, 1'b0);
    rd(a(i2c_ctrl_pkg::IDX_STAT), 8'h08, 8'h08);
    chk("ackLog", 8'h01, {5'h0, ackLog[2:0]});
    // One byte at a time: SCL must stay low once the byte is done
    wr(a(i2c_ctrl_pkg::IDX_CTRL1), 8'he5);
    wr(a(i2c_ctrl_pkg::IDX_CTRL2), 8'h40);
    waitb(a(i2c_ctrl_pkg::IDX_STAT), 6, 1'b1);
    rd(a(i2c_ctrl_pkg::IDX_RXD), 8'hff, expQ.pop_front());
    sclTo(1'b1, n);
    sclTo(1'b0, n);
    repeat (150) @(posedge clk);
    chk("sclHeldLow", 8'h00, {7'h0, sclW});
    wr(a(i2c_ctrl_pkg::IDX_CTRL2), 8'h20);
    waitb(a(i2c_ctrl_pkg::IDX_CTRL2), 7, 1'b0);
    chk("ackLog", 8'h03, {4'h0, ackLog[3:0]});
    wr(a(i2c_ctrl_pkg::IDX_STAT), 8'h08);
    rd(a(i2c_ctrl_pkg::IDX_STAT), 8'h08, 8'h00);
    wr(a(i2c_ctrl_pkg::IDX_TXD), tx);
    rd(a(i2c_ctrl_pkg::IDX_TXD), 8'hff, tx);
    rd(a(i2c_ctrl_pkg::IDX_STAT), 8'h80, 8'h00);
    chk("dmaTxReq", 8'h00, {7'h0, dmaTxReq});
    test_done();
  end
endmodule : i2c_master_receive_controller_tb
